/* pss_pkg.sv */
package pss_pkg;
  localparam int DW = 16;
  localparam int AW = 8;
  localparam int N_MFI = 7;
  localparam int N_CFG = 16;
  localparam int N_IRQ = 4;

  // Config word indices; byte offset is index times the stride
  localparam logic [3:0] CFG_MAX_FREQ = 4'h0;
  localparam logic [3:0] CFG_LIM_HI = 4'h1;
  localparam logic [3:0] CFG_LIM_LO = 4'h2;
  localparam logic [3:0] CFG_RAMP_FREQ = 4'h3;
  localparam logic [3:0] CFG_RAMP_EXIT = 4'h4;
  localparam logic [3:0] CFG_RAMP_TMO = 4'h5;
  localparam logic [3:0] CFG_SLEEP_DT = 4'h6;
  localparam logic [3:0] CFG_SLEEP_FREQ = 4'h7;
  localparam logic [3:0] CFG_WAKE_LVL = 4'h8;
  localparam logic [3:0] CFG_WAKE_SEL = 4'h9;
  localparam logic [3:0] CFG_P_GAIN = 4'ha;
  localparam logic [3:0] CFG_I_GAIN = 4'hb;
  localparam logic [3:0] CFG_ALT_GAIN = 4'hc;
  localparam logic [3:0] CFG_UNIT_GAIN = 4'hd;
  localparam logic [3:0] CFG_UNIT_SCALE = 4'he;
  localparam logic [3:0] CFG_UNIT_SEL = 4'hf;

  // Byte addresses
  localparam logic [AW-1:0] REG_STRIDE = 8'h04;
  localparam logic [AW-1:0] OFS_CFG_TOP = 8'h40;
  localparam logic [AW-1:0] OFS_MFI_BASE = 8'h40;
  localparam logic [AW-1:0] OFS_MFI_TOP = 8'h5c;
  localparam logic [AW-1:0] OFS_STATUS = 8'h60;
  localparam logic [AW-1:0] OFS_INT_STAT = 8'h64;
  localparam logic [AW-1:0] OFS_INT_MASK = 8'h68;
  localparam logic [AW-1:0] OFS_DISP = 8'h6c;

  // Reset values, in config index order
  localparam logic [DW-1:0] CFG_RST [N_CFG] = '{
    16'h1770, 16'h03e8, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0064, 16'h0000,
    16'h0000, 16'h0000, 16'h0064, 16'h0064, 16'h00c8, 16'h0001, 16'h0000, 16'h0000};
  localparam logic [7:0] MFI_CODE_RST = 8'h00;
  localparam logic [N_IRQ-1:0] INT_MASK_RST = 4'h0;

  // Terminal function codes
  localparam logic [7:0] FN_LOOP_BYPASS = 8'h17;
  localparam logic [7:0] FN_ALT_GAIN = 8'h18;

  // Percent in tenths: this value is full scale
  localparam logic [DW-1:0] PCT_FULL = 16'h03e8;
  localparam logic [DW-1:0] TMR_MAX = 16'hffff;
  localparam logic [DW-1:0] UNIT_DIV [4] = '{16'h0001, 16'h000a, 16'h0064, 16'h03e8};

  localparam logic [1:0] WAKE_BELOW = 2'h0;
  localparam logic [1:0] WAKE_ABOVE = 2'h1;
  localparam logic [1:0] WAKE_BEYOND = 2'h2;

  localparam int IRQ_FAIL = 0;
  localparam int IRQ_SLEEP = 1;
  localparam int IRQ_WAKE = 2;
  localparam int IRQ_BYPASS = 3;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_RAMP = 3'b001,
    ST_PID = 3'b010,
    ST_OPEN = 3'b011,
    ST_SLEEP = 3'b100,
    ST_FAIL = 3'b101
  } pss_state_t;

  typedef struct packed {
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
    logic wr;
    logic rd;
  } pss_bus_t;
endpackage : pss_pkg

/* pss_plant.sv */
`timescale 1ns/10ps
// Drive stage and process sensor: the sensor reports one cycle late
module pss_plant (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic run_out,
  input wire logic [pss_pkg::DW-1:0] freq_cmd,
  input wire logic [pss_pkg::DW-1:0] fb_set,
  output logic [pss_pkg::DW-1:0] feedback,
  output logic [pss_pkg::DW-1:0] motor_hz
);
  // Sensor lag, so the block never sees a same-edge change
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) feedback <= '0;
    else feedback <= fb_set;
  end
  // A stopped drive turns nothing, whatever the command
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) motor_hz <= '0;
    else motor_hz <= run_out ? freq_cmd : '0;
  end
endmodule : pss_plant

/* pss_scaler.sv */
`timescale 1ns/10ps
module pss_scaler (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic clk_en,
  input wire logic [pss_pkg::DW-1:0] pct_in,
  input wire logic [pss_pkg::DW-1:0] lim_lo,
  input wire logic [pss_pkg::DW-1:0] lim_hi,
  input wire logic [pss_pkg::DW-1:0] max_freq,
  output logic [pss_pkg::DW-1:0] pct_out,
  output logic [pss_pkg::DW-1:0] hz_out
);
  logic [pss_pkg::DW-1:0] pct_clamp;
  logic [31:0] hz_full;

  // Clamp; negative input lands on the lower limit, keeping output unipolar
  always_comb begin
    pct_clamp = pct_in;
    if ($signed(pct_in) < $signed(lim_lo)) begin
      pct_clamp = lim_lo;
    end else if ($signed(pct_in) > $signed(lim_hi)) begin
      pct_clamp = lim_hi;
    end
  end

  // Full scale percent maps to the maximum frequency
  assign hz_full = ({16'h0000, pct_clamp} * {16'h0000, max_freq}) / {16'h0000, pss_pkg::PCT_FULL};

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      pct_out <= '0;
      hz_out <= '0;
    end else if (clk_en) begin
      pct_out <= pct_clamp;
      hz_out <= hz_full[15:0];
    end
  end

  property p_clamp;
    @(posedge clk_sys) disable iff (!resetn)
    (clk_en && $signed(lim_lo) <= $signed(lim_hi)) |=>
      ($signed(pct_out) >= $signed($past(lim_lo)) && $signed(pct_out) <= $signed($past(lim_hi)));
  endproperty
  a_clamp: assert property (p_clamp) else $error("output outside limits");

  property p_full;
    @(posedge clk_sys) disable iff (!resetn)
    (clk_en && pct_clamp == pss_pkg::PCT_FULL) |=> (hz_out == $past(max_freq));
  endproperty
  a_full: assert property (p_full) else $error("full scale not at max frequency");
endmodule : pss_scaler

/* pss_sequencer.sv */
// Operation
// - Terminal coded 24 active swaps proportional and integral gains for the alternate gain.
// - Loop bypass from a terminal turns the percent command into a frequency.
// - Normal loop output is unipolar and clamped between upper and lower limits.
// - Percent of 100.0 equals the configured maximum output frequency.
// - Ramp phase drives the ramp frequency until feedback passes the exit level.
// - Feedback above the exit level ends the ramp phase and starts closed loop.
// - Nonzero timeout with feedback held low raises the ramp failure trip, output blocked.
// - Output below sleep threshold for the sleep delay stops operation and sleeps.
// - Sleeping keeps operation stopped until the chosen wake condition holds.
// - Wake mode 0 resumes when feedback falls below the wake level.
// - Wake mode 1 resumes when feedback rises above the wake level.
// - Wake mode 2 resumes when reference minus feedback exceeds the wake level.
// - Terminal coded 23 on suspends closed loop; off restarts it.
// - Unit gain and unit scale size the displayed feedback value.
`timescale 1ns/10ps
module pss_sequencer (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic clk_en,
  input wire logic tick,
  input wire pss_pkg::pss_bus_t bus,
  output logic [pss_pkg::DW-1:0] rd_data,
  input wire logic run_pin,
  input wire logic [pss_pkg::N_MFI-1:0] mfi_pin,
  input wire logic [pss_pkg::DW-1:0] feedback,
  input wire logic [pss_pkg::DW-1:0] reference,
  input wire logic [pss_pkg::DW-1:0] pid_pct,
  output logic [pss_pkg::DW-1:0] freq_cmd,
  output logic [pss_pkg::DW-1:0] loop_output,
  output logic [pss_pkg::DW-1:0] gain_p,
  output logic [pss_pkg::DW-1:0] gain_i,
  output logic run_out,
  output logic ramp_phase_failure_trip,
  output logic sleep_out,
  output logic irq
);
  pss_pkg::pss_state_t state_r;
  pss_pkg::pss_state_t state_nxt;
  logic [pss_pkg::DW-1:0] cfg_r [pss_pkg::N_CFG];
  logic [7:0] mfi_code_r [pss_pkg::N_MFI];
  logic [pss_pkg::N_MFI-1:0] mfi_meta_r;
  logic [pss_pkg::N_MFI-1:0] mfi_sync_r;
  logic run_meta_r;
  logic run_sync_r;
  logic [pss_pkg::N_MFI-1:0] bypass_hit;
  logic [pss_pkg::N_MFI-1:0] alt_hit;
  logic loop_bypass_input;
  logic alt_gain_select;
  logic [pss_pkg::DW-1:0] loop_hz;
  logic [pss_pkg::DW-1:0] ref_pct;
  logic [pss_pkg::DW-1:0] ref_hz;
  logic sleep_cond;
  logic sleep_done;
  logic ramp_cond;
  logic ramp_done;
  logic wake_hit;
  logic [pss_pkg::DW-1:0] diff;
  logic [pss_pkg::N_IRQ-1:0] int_stat_r;
  logic [pss_pkg::N_IRQ-1:0] int_mask_r;
  logic [pss_pkg::N_IRQ-1:0] int_ev;
  logic [pss_pkg::N_IRQ-1:0] int_clr;
  logic [pss_pkg::DW-1:0] disp_r;
  logic [31:0] disp_nxt;
  logic [2:0] mfi_idx;
  logic cfg_sel;
  logic mfi_sel;

  // Pins cross into the clock domain through two flops each
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      mfi_meta_r <= '0;
      mfi_sync_r <= '0;
      run_meta_r <= 1'b0;
      run_sync_r <= 1'b0;
    end else if (clk_en) begin
      mfi_meta_r <= mfi_pin;
      mfi_sync_r <= mfi_meta_r;
      run_meta_r <= run_pin;
      run_sync_r <= run_meta_r;
    end
  end

  // Bus decode helpers; misaligned addresses map to nothing
  assign cfg_sel = (bus.addr[1:0] == 2'h0) && (bus.addr < pss_pkg::OFS_CFG_TOP);
  assign mfi_sel = (bus.addr[1:0] == 2'h0) && (bus.addr >= pss_pkg::OFS_MFI_BASE) &&
                   (bus.addr < pss_pkg::OFS_MFI_TOP);
  assign mfi_idx = bus.addr[4:2];

  // Per terminal function code and its decoded hits
  for (genvar g = 0; g < pss_pkg::N_MFI; g++) begin : g_mfi
    always_ff @(posedge clk_sys or negedge resetn) begin
      if (!resetn) begin
        mfi_code_r[g] <= pss_pkg::MFI_CODE_RST;
      end else if (clk_en && bus.wr && mfi_sel && mfi_idx == 3'(g)) begin
        mfi_code_r[g] <= bus.wdata[7:0];
      end
    end
    assign bypass_hit[g] = mfi_sync_r[g] && (mfi_code_r[g] == pss_pkg::FN_LOOP_BYPASS);
    assign alt_hit[g] = mfi_sync_r[g] && (mfi_code_r[g] == pss_pkg::FN_ALT_GAIN);
  end

  assign loop_bypass_input = |bypass_hit;
  assign alt_gain_select = |alt_hit;

  // Configuration words
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      for (int k = 0; k < pss_pkg::N_CFG; k++) begin
        cfg_r[k] <= pss_pkg::CFG_RST[k];
      end
    end else if (clk_en && bus.wr && cfg_sel) begin
      cfg_r[bus.addr[5:2]] <= bus.wdata;
    end
  end

  // Loop output path: clamp then convert to frequency
  pss_scaler u_loop (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .clk_en(clk_en),
    .pct_in(pid_pct),
    .lim_lo(cfg_r[pss_pkg::CFG_LIM_LO]),
    .lim_hi(cfg_r[pss_pkg::CFG_LIM_HI]),
    .max_freq(cfg_r[pss_pkg::CFG_MAX_FREQ]),
    .pct_out(loop_output),
    .hz_out(loop_hz)
  );

  // Bypass path: percent reference becomes a frequency command
  pss_scaler u_bypass (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .clk_en(clk_en),
    .pct_in(reference),
    .lim_lo('0),
    .lim_hi(pss_pkg::PCT_FULL),
    .max_freq(cfg_r[pss_pkg::CFG_MAX_FREQ]),
    .pct_out(ref_pct),
    .hz_out(ref_hz)
  );

  // Sleep delay runs only while closed loop sits under the threshold
  assign sleep_cond = (state_r == pss_pkg::ST_PID) && !loop_bypass_input &&
                      (loop_hz < cfg_r[pss_pkg::CFG_SLEEP_FREQ]);

  pss_timer u_sleep_tmr (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .clk_en(clk_en),
    .tick(tick),
    .cond(sleep_cond),
    .limit(cfg_r[pss_pkg::CFG_SLEEP_DT]),
    .done(sleep_done)
  );

  // Ramp timeout runs while feedback has not passed the exit level
  assign ramp_cond = (state_r == pss_pkg::ST_RAMP) && (feedback <= cfg_r[pss_pkg::CFG_RAMP_EXIT]);

  pss_timer u_ramp_tmr (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .clk_en(clk_en),
    .tick(tick),
    .cond(ramp_cond),
    .limit(cfg_r[pss_pkg::CFG_RAMP_TMO]),
    .done(ramp_done)
  );

  // Wake condition select; mode 2 needs reference above feedback
  assign diff = reference - feedback;
  always_comb begin
    case (cfg_r[pss_pkg::CFG_WAKE_SEL][1:0])
      pss_pkg::WAKE_BELOW: wake_hit = feedback < cfg_r[pss_pkg::CFG_WAKE_LVL];
      pss_pkg::WAKE_ABOVE: wake_hit = feedback > cfg_r[pss_pkg::CFG_WAKE_LVL];
      pss_pkg::WAKE_BEYOND: wake_hit = (reference > feedback) && (diff > cfg_r[pss_pkg::CFG_WAKE_LVL]);
      default: wake_hit = 1'b0;
    endcase
  end

  // Sequencer; the failure state only leaves through reset
  always_comb begin
    state_nxt = state_r;
    if (state_r != pss_pkg::ST_FAIL && !run_sync_r) begin
      state_nxt = pss_pkg::ST_IDLE;
    end else begin
      case (state_r)
        pss_pkg::ST_IDLE: begin
          if (cfg_r[pss_pkg::CFG_RAMP_FREQ] != '0) begin
            state_nxt = pss_pkg::ST_RAMP;
          end else begin
            state_nxt = pss_pkg::ST_PID;
          end
        end
        pss_pkg::ST_RAMP: begin
          if (feedback > cfg_r[pss_pkg::CFG_RAMP_EXIT]) begin
            state_nxt = pss_pkg::ST_PID;
          end else if (cfg_r[pss_pkg::CFG_RAMP_TMO] != '0 && ramp_done) begin
            state_nxt = pss_pkg::ST_FAIL;
          end
        end
        pss_pkg::ST_PID: begin
          if (loop_bypass_input) begin
            state_nxt = pss_pkg::ST_OPEN;
          end else if (sleep_done) begin
            state_nxt = pss_pkg::ST_SLEEP;
          end
        end
        pss_pkg::ST_OPEN: begin
          if (!loop_bypass_input) begin
            state_nxt = pss_pkg::ST_PID;
          end
        end
        pss_pkg::ST_SLEEP: begin
          if (wake_hit) begin
            state_nxt = pss_pkg::ST_PID;
          end
        end
        default: state_nxt = state_r;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state_r <= pss_pkg::ST_IDLE;
    end else if (clk_en) begin
      state_r <= state_nxt;
    end
  end

  // Drive outputs from the next state so they line up with state_r
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      run_out <= 1'b0;
      ramp_phase_failure_trip <= 1'b0;
      sleep_out <= 1'b0;
      freq_cmd <= '0;
    end else if (clk_en) begin
      run_out <= (state_nxt == pss_pkg::ST_RAMP) || (state_nxt == pss_pkg::ST_PID) ||
                 (state_nxt == pss_pkg::ST_OPEN);
      ramp_phase_failure_trip <= state_nxt == pss_pkg::ST_FAIL;
      sleep_out <= state_nxt == pss_pkg::ST_SLEEP;
      case (state_nxt)
        pss_pkg::ST_RAMP: freq_cmd <= cfg_r[pss_pkg::CFG_RAMP_FREQ];
        pss_pkg::ST_PID: freq_cmd <= loop_hz;
        pss_pkg::ST_OPEN: freq_cmd <= ref_hz;
        default: freq_cmd <= '0;
      endcase
    end
  end

  // Gain selection for the loop arithmetic outside
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      gain_p <= pss_pkg::CFG_RST[pss_pkg::CFG_P_GAIN];
      gain_i <= pss_pkg::CFG_RST[pss_pkg::CFG_I_GAIN];
    end else if (clk_en) begin
      gain_p <= alt_gain_select ? cfg_r[pss_pkg::CFG_ALT_GAIN] : cfg_r[pss_pkg::CFG_P_GAIN];
      gain_i <= alt_gain_select ? cfg_r[pss_pkg::CFG_ALT_GAIN] : cfg_r[pss_pkg::CFG_I_GAIN];
    end
  end

  // Display value; constant divisors keep the dividers cheap
  always_comb begin
    disp_nxt = {16'h0000, feedback} * {16'h0000, cfg_r[pss_pkg::CFG_UNIT_GAIN]};
    case (cfg_r[pss_pkg::CFG_UNIT_SCALE][1:0])
      2'h1: disp_nxt = disp_nxt / {16'h0000, pss_pkg::UNIT_DIV[1]};
      2'h2: disp_nxt = disp_nxt / {16'h0000, pss_pkg::UNIT_DIV[2]};
      2'h3: disp_nxt = disp_nxt / {16'h0000, pss_pkg::UNIT_DIV[3]};
      default: disp_nxt = disp_nxt / {16'h0000, pss_pkg::UNIT_DIV[0]};
    endcase
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      disp_r <= '0;
    end else if (clk_en) begin
      disp_r <= disp_nxt[15:0];
    end
  end

  // Sticky events; a set in the clearing cycle wins
  always_comb begin
    int_ev = '0;
    int_ev[pss_pkg::IRQ_FAIL] = state_r != pss_pkg::ST_FAIL && state_nxt == pss_pkg::ST_FAIL;
    int_ev[pss_pkg::IRQ_SLEEP] = state_r != pss_pkg::ST_SLEEP && state_nxt == pss_pkg::ST_SLEEP;
    int_ev[pss_pkg::IRQ_WAKE] = state_r == pss_pkg::ST_SLEEP && state_nxt == pss_pkg::ST_PID;
    int_ev[pss_pkg::IRQ_BYPASS] = state_r != pss_pkg::ST_OPEN && state_nxt == pss_pkg::ST_OPEN;
  end

  assign int_clr = (bus.wr && bus.addr == pss_pkg::OFS_INT_STAT) ? bus.wdata[pss_pkg::N_IRQ-1:0] : '0;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      int_stat_r <= '0;
      int_mask_r <= pss_pkg::INT_MASK_RST;
    end else if (clk_en) begin
      int_stat_r <= (int_stat_r & ~int_clr) | int_ev;
      if (bus.wr && bus.addr == pss_pkg::OFS_INT_MASK) begin
        int_mask_r <= bus.wdata[pss_pkg::N_IRQ-1:0];
      end
    end
  end

  assign irq = |(int_stat_r & int_mask_r);

  // Read data stand for the one cycle after the strobe, zero otherwise
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rd_data <= '0;
    end else if (clk_en) begin
      if (!bus.rd) begin
        rd_data <= '0;
      end else if (cfg_sel) begin
        rd_data <= cfg_r[bus.addr[5:2]];
      end else if (mfi_sel) begin
        rd_data <= {8'h00, mfi_code_r[mfi_idx]};
      end else if (bus.addr == pss_pkg::OFS_STATUS) begin
        rd_data <= 16'({alt_gain_select, loop_bypass_input, sleep_out, ramp_phase_failure_trip, run_out, state_r});
      end else if (bus.addr == pss_pkg::OFS_INT_STAT) begin
        rd_data <= 16'(int_stat_r);
      end else if (bus.addr == pss_pkg::OFS_INT_MASK) begin
        rd_data <= 16'(int_mask_r);
      end else if (bus.addr == pss_pkg::OFS_DISP) begin
        rd_data <= disp_r;
      end else begin
        rd_data <= '0;
      end
    end
  end

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!resetn);

  property p_alt_gain;
    (clk_en && alt_gain_select) |=> (gain_p == $past(cfg_r[pss_pkg::CFG_ALT_GAIN]) &&
      gain_i == $past(cfg_r[pss_pkg::CFG_ALT_GAIN]));
  endproperty
  a_alt_gain: assert property (p_alt_gain) else $error("alternate gain not applied");

  property p_bypass_freq;
    (clk_en && state_nxt == pss_pkg::ST_OPEN) |=> (freq_cmd == $past(ref_hz) && run_out);
  endproperty
  a_bypass_freq: assert property (p_bypass_freq) else $error("bypass frequency wrong");

  property p_ramp_freq;
    (clk_en && state_nxt == pss_pkg::ST_RAMP) |=> (freq_cmd == $past(cfg_r[pss_pkg::CFG_RAMP_FREQ]));
  endproperty
  a_ramp_freq: assert property (p_ramp_freq) else $error("ramp frequency wrong");

  property p_ramp_exit;
    (clk_en && run_sync_r && state_r == pss_pkg::ST_RAMP && feedback > cfg_r[pss_pkg::CFG_RAMP_EXIT])
      |=> (state_r == pss_pkg::ST_PID);
  endproperty
  a_ramp_exit: assert property (p_ramp_exit) else $error("ramp phase did not exit");

  property p_fail_block;
    ramp_phase_failure_trip |-> (!run_out && freq_cmd == '0) ##1 ramp_phase_failure_trip;
  endproperty
  a_fail_block: assert property (p_fail_block) else $error("failure trip not latched or output live");

  property p_sleep_entry;
    (clk_en && run_sync_r && sleep_done && state_r == pss_pkg::ST_PID && !loop_bypass_input)
      |=> (sleep_out && !run_out && freq_cmd == '0);
  endproperty
  a_sleep_entry: assert property (p_sleep_entry) else $error("sleep not entered");

  property p_wake;
    (clk_en && run_sync_r && state_r == pss_pkg::ST_SLEEP) |=> (run_out == $past(wake_hit));
  endproperty
  a_wake: assert property (p_wake) else $error("wake decision wrong");

  property p_bypass_back;
    (clk_en && run_sync_r && state_r == pss_pkg::ST_OPEN && !loop_bypass_input)
      |=> (state_r == pss_pkg::ST_PID);
  endproperty
  a_bypass_back: assert property (p_bypass_back) else $error("closed loop not restarted");

  c_sleep_wake: cover property (state_r == pss_pkg::ST_SLEEP ##[1:200] state_r == pss_pkg::ST_PID);
  c_ramp_fail: cover property (state_r == pss_pkg::ST_RAMP ##[1:200] ramp_phase_failure_trip);
  c_bypass: cover property (state_r == pss_pkg::ST_OPEN ##[1:200] state_r == pss_pkg::ST_PID);
endmodule : pss_sequencer

/* pss_timer.sv */
`timescale 1ns/10ps
module pss_timer (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic clk_en,
  input wire logic tick,
  input wire logic cond,
  input wire logic [pss_pkg::DW-1:0] limit,
  output logic done
);
  logic [pss_pkg::DW-1:0] cnt_r;

  // Tick counter, saturates so a long wait never wraps back to zero
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      cnt_r <= '0;
    end else if (clk_en) begin
      if (!cond) begin
        cnt_r <= '0;
      end else if (tick && cnt_r != pss_pkg::TMR_MAX) begin
        cnt_r <= cnt_r + 16'h0001;
      end
    end
  end

  assign done = cond && (cnt_r >= limit);

  property p_restart;
    @(posedge clk_sys) disable iff (!resetn)
    (clk_en && !cond) |=> (cnt_r == '0);
  endproperty
  a_restart: assert property (p_restart) else $error("timer did not restart");
endmodule : pss_timer

/* tb.sv */
`timescale 1ns/10ps
module tb;
  logic clk_sys = 1'b0, resetn = 1'b0, tick = 1'b0, run_pin = 1'b0, clk_en = 1'b1;
  logic [1:0] tcnt = 2'h0;
  logic [6:0] mfi_pin = 7'h00;
  logic [15:0] fb_set = 16'h0000, reference = 16'h0000, pid_pct = 16'h0000, v;
  logic [15:0] feedback, rd_data, freq_cmd, loop_output, gain_p, gain_i;
  logic run_out, trip, sleep_out, irq;
  pss_pkg::pss_bus_t bus = '0;
  int n_mismatch = 0, total_checks = 0;
  always #2 clk_sys = ~clk_sys;
  // Timebase: one tick every fourth cycle
  always @(posedge clk_sys) begin
    tcnt <= tcnt + 2'h1;
    tick <= (tcnt == 2'h3);
  end
  pss_plant i_pss_plant (.clk_sys(clk_sys), .resetn(resetn), .run_out(run_out), .freq_cmd(freq_cmd),
    .fb_set(fb_set), .feedback(feedback), .motor_hz());
  pss_sequencer i_pss_sequencer (.clk_sys(clk_sys), .resetn(resetn), .clk_en(clk_en), .tick(tick), .bus(bus),
    .rd_data(rd_data), .run_pin(run_pin), .mfi_pin(mfi_pin), .feedback(feedback), .reference(reference),
    .pid_pct(pid_pct), .freq_cmd(freq_cmd), .loop_output(loop_output), .gain_p(gain_p), .gain_i(gain_i),
    .run_out(run_out), .ramp_phase_failure_trip(trip), .sleep_out(sleep_out), .irq(irq));
  function automatic logic [7:0] ca(input logic [3:0] idx);
    return {2'b00, idx, 2'b00};
  endfunction : ca
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : cyc
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys);
    bus.wr <= 1'b0;
  endtask : wr
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge clk_sys);
    bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys);
    bus.rd <= 1'b0;
    @(negedge clk_sys);
    v = rd_data;
  endtask : rd
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : wrap_up
  // Ramp phase, its exit, then output clamping and scaling
  task automatic t_ramp_loop;
    wr(ca(pss_pkg::CFG_RAMP_FREQ), 16'h0010);
    wr(ca(pss_pkg::CFG_RAMP_EXIT), 16'h0100);
    @(posedge clk_sys) run_pin <= 1'b1;
    cyc(8);
    rd(pss_pkg::OFS_STATUS);
    chk("ramp state", 16'h0001, v & 16'h0007);
    chk("ramp freq", 16'h0010, freq_cmd);
    // Enable low: feedback passes the exit level, yet the ramp state must hold
    @(posedge clk_sys) clk_en <= 1'b0;
    fb_set <= 16'h0200;
    cyc(6);
    chk("frozen run", 16'h0001, {15'h0, run_out});
    chk("frozen freq", 16'h0010, freq_cmd);
    @(posedge clk_sys) clk_en <= 1'b1;
    cyc(6);
    rd(pss_pkg::OFS_STATUS);
    chk("loop state", 16'h0002, v & 16'h0007);
    @(posedge clk_sys) pid_pct <= 16'h01f4;
    cyc(4);
    chk("half out", 16'h01f4, loop_output);
    chk("half hz", 16'h0bb8, freq_cmd);
    @(posedge clk_sys) pid_pct <= 16'h0500;
    cyc(4);
    chk("upper clamp", 16'h03e8, loop_output);
    chk("full hz", 16'h1770, freq_cmd);
    @(posedge clk_sys) pid_pct <= 16'hff00;
    cyc(4);
    chk("lower clamp", 16'h0000, loop_output);
  endtask : t_ramp_loop
  // Alternate gain terminal, then bypass with its interrupt
  task automatic t_terminals;
    wr(pss_pkg::OFS_MFI_BASE, 16'h0018);
    @(posedge clk_sys) mfi_pin[0] <= 1'b1;
    cyc(5);
    chk("gain p", 16'h00c8, gain_p);
    chk("gain i", 16'h00c8, gain_i);
    @(posedge clk_sys) mfi_pin[0] <= 1'b0;
    wr(pss_pkg::OFS_MFI_BASE + 8'h04, 16'h0017);
    @(posedge clk_sys) reference <= 16'h00fa;
    mfi_pin[1] <= 1'b1;
    cyc(8);
    rd(pss_pkg::OFS_STATUS);
    chk("bypass state", 16'h0003, v & 16'h0007);
    chk("bypass hz", 16'h05dc, freq_cmd);
    chk("irq masked", 16'h0000, {15'h0, irq});
    wr(pss_pkg::OFS_INT_MASK, 16'h0008);
    cyc(1);
    chk("irq unmasked", 16'h0001, {15'h0, irq});
    wr(pss_pkg::OFS_INT_STAT, 16'h000f);
    cyc(1);
    chk("irq cleared", 16'h0000, {15'h0, irq});
    @(posedge clk_sys) mfi_pin[1] <= 1'b0;
    cyc(6);
    rd(pss_pkg::OFS_STATUS);
    chk("bypass off", 16'h0002, v & 16'h0007);
    rd(8'h7c);
    chk("unmapped", 16'h0000, v);
  endtask : t_terminals
  // Sleep entry, then each wake condition refused and met
  task automatic t_sleep;
    logic [15:0] nw [3] = '{16'h0300, 16'h0100, 16'h0300};
    logic [15:0] wk [3] = '{16'h0100, 16'h0300, 16'h0100};
    @(posedge clk_sys) pid_pct <= 16'h0000;
    reference <= 16'h0400;
    wr(ca(pss_pkg::CFG_SLEEP_DT), 16'h0003);
    wr(ca(pss_pkg::CFG_SLEEP_FREQ), 16'h0064);
    cyc(40);
    chk("sleeping", 16'h0001, {15'h0, sleep_out});
    chk("stopped", 16'h0000, {15'h0, run_out});
    wr(ca(pss_pkg::CFG_WAKE_LVL), 16'h0200);
    for (int m = 0; m < 3; m++) begin
      @(posedge clk_sys) fb_set <= nw[m];
      wr(ca(pss_pkg::CFG_WAKE_SEL), m[15:0]);
      cyc(40);
      wr(pss_pkg::OFS_INT_STAT, 16'h000f);
      cyc(20);
      rd(pss_pkg::OFS_INT_STAT);
      chk("no wake", 16'h0000, v & 16'h0004);
      chk("still asleep", 16'h0001, {15'h0, sleep_out});
      @(posedge clk_sys) fb_set <= wk[m];
      cyc(20);
      rd(pss_pkg::OFS_INT_STAT);
      chk("wake", 16'h0004, v & 16'h0004);
    end
  endtask : t_sleep
  // Display sizing, then a ramp that never exits
  task automatic t_disp_fail;
    wr(ca(pss_pkg::CFG_UNIT_GAIN), 16'h0002);
    wr(ca(pss_pkg::CFG_UNIT_SCALE), 16'h0001);
    @(posedge clk_sys) fb_set <= 16'h0064;
    run_pin <= 1'b0;
    cyc(6);
    rd(pss_pkg::OFS_DISP);
    chk("display", 16'h0014, v);
    wr(ca(pss_pkg::CFG_RAMP_TMO), 16'h0003);
    @(posedge clk_sys) run_pin <= 1'b1;
    cyc(40);
    chk("trip", 16'h0001, {15'h0, trip});
    chk("blocked", 16'h0000, {15'h0, run_out});
    @(posedge clk_sys) run_pin <= 1'b0;
    fb_set <= 16'h0300;
    cyc(20);
    rd(pss_pkg::OFS_STATUS);
    chk("fail held", 16'h0005, v & 16'h0007);
    chk("trip held", 16'h0001, {15'h0, trip});
    // Only a reset clears the latched trip
    @(posedge clk_sys) resetn <= 1'b0;
    cyc(2);
    @(posedge clk_sys) resetn <= 1'b1;
    cyc(2);
    chk("trip reset", 16'h0000, {15'h0, trip});
  endtask : t_disp_fail
  // Watchdog: the tests need roughly five hundred cycles
  initial begin
    #40000;
    n_mismatch++;
    wrap_up();
  end
  initial begin
    cyc(6);
    resetn <= 1'b1;
    chk("gain reset", 16'h0064, gain_p);
    t_ramp_loop();
    t_terminals();
    t_sleep();
    t_disp_fail();
    wrap_up();
  end
endmodule : tb
